// ### rtl/fbs_pkg.sv
// shared types and constants for the fieldbus slave state machine
package fbs_pkg;

	typedef enum logic [3:0] {
		FBS_TG_SET_ADDR,
		FBS_TG_SET_PRM,
		FBS_TG_CHK_CFG,
		FBS_TG_GET_CFG,
		FBS_TG_DATA_EXCH,
		FBS_TG_RD_INP,
		FBS_TG_RD_OUTP,
		FBS_TG_GLOBAL_CTRL,
		FBS_TG_SLAVE_DIAG,
		FBS_TG_OTHER
	} fbs_tg_t;

	typedef enum logic [1:0] {
		FBS_CHK_OK,
		FBS_CHK_BAD,
		FBS_CHK_ADAPT
	} fbs_chk_t;

	typedef enum logic [1:0] {
		FBS_ST_POWER_ON,
		FBS_ST_WAIT_PRM,
		FBS_ST_WAIT_CFG,
		FBS_ST_DATA_EXCH
	} fbs_state_t;

	localparam int FBS_ADDR_W = 7;
	localparam int FBS_CNT_W  = 8;

	// telegram as decoded by the line layer
	typedef struct packed {
		fbs_tg_t                tg;
		logic                   from_class2;
		logic [FBS_ADDR_W-1:0]  new_addr;
		logic [15:0]            ident;
		logic                   sync_ok;
		logic                   freeze_ok;
		logic [15:0]            wd_time;
		logic [FBS_CNT_W-1:0]   in_bytes;
		logic [FBS_CNT_W-1:0]   out_bytes;
	} fbs_tel_t;

	// held parameter and configuration set
	typedef struct packed {
		logic [15:0]            ident;
		logic                   sync_ok;
		logic                   freeze_ok;
		logic [15:0]            wd_time;
		logic [FBS_CNT_W-1:0]   in_bytes;
		logic [FBS_CNT_W-1:0]   out_bytes;
	} fbs_set_t;

	localparam logic [FBS_ADDR_W-1:0] FBS_ADDR_RST  = 7'h7E;
	localparam int                    FBS_RUNUP_CYC = 4;
	localparam logic [2:0]            FBS_RUNUP_W3  = 3'h4;

endpackage

// ### rtl/fbs_runup.sv
// internal run-up delay after reset
`timescale 1ns/1ns
module fbs_runup #(
	parameter logic [2:0] CYCLES = fbs_pkg::FBS_RUNUP_W3
) (
	input  wire logic ref_clk,
	input  wire logic rst_n,
	input  wire logic start,
	output logic      done
);
	import fbs_pkg::*;

	logic [2:0] cnt;
	logic [2:0] next_cnt;
	logic       next_done;

	// count once start is seen, hold done afterwards
	always_comb begin
		next_cnt  = cnt;
		next_done = done;
		if (start && !done) begin
			if (cnt == CYCLES - 3'h1) begin
				next_done = 1'b1;
			end else begin
				next_cnt = cnt + 3'h1;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt  <= 3'h0;
			done <= 1'b0;
		end else begin
			cnt  <= next_cnt;
			done <= next_done;
		end
	end
endmodule

// ### rtl/fbs_slave_fsm.sv
// slave-side telegram acceptance state machine
// Notes on behaviour
// - address change from class 2 master accepted only in power-on state
// - assigned address kept in non-volatile store through power cycles
// - after run-up only parameter, class 2 address change or config query accepted, rest refused
// - no cyclic data exchange while awaiting parameters
// - parameter telegram carries ident, sync/freeze, watchdog; user bytes optional
// - config telegram sets input and output byte counts per cycle
// - received config passed to application, returns ok, bad or adaptable
// - config query accepted in every state, except in the cycle a config verdict is taken
// - data exchange only after parameters and config both accepted
// - data exchange state accepts the listed telegram set
`timescale 1ns/1ns
module fbs_slave_fsm (
	input  wire logic                         ref_clk,
	input  wire logic                         reset_n,
	input  wire logic                         tel_valid,
	input  wire fbs_pkg::fbs_tel_t            tel,
	input  wire logic [fbs_pkg::FBS_ADDR_W-1:0] nv_addr,
	input  wire logic                         nv_addr_valid,
	input  wire logic                         chk_done,
	input  wire fbs_pkg::fbs_chk_t            chk_result,
	output logic                              tel_accept,
	output logic                              tel_reject,
	output logic                              nv_write,
	output logic [fbs_pkg::FBS_ADDR_W-1:0]    station_addr,
	output logic                              chk_req,
	output fbs_pkg::fbs_set_t                 chk_cfg,
	output fbs_pkg::fbs_set_t                 active_set,
	output logic                              cfg_reply,
	output logic                              data_xfer,
	output logic                              sync_cmd,
	output logic                              diag_reply,
	output fbs_pkg::fbs_state_t               state
);
	import fbs_pkg::*;

	logic       rst_s1;
	logic       rst_n_i;
	logic       run_done;
	logic       addr_loaded;
	logic       next_addr_loaded;
	logic       chk_busy;
	logic       next_chk_busy;
	fbs_state_t next_state;
	logic [FBS_ADDR_W-1:0] next_station_addr;
	fbs_set_t   prm_hold;
	fbs_set_t   next_prm_hold;
	fbs_set_t   next_active_set;
	fbs_set_t   next_chk_cfg;
	logic       next_accept;
	logic       next_reject;
	logic       next_nv_write;
	logic       next_chk_req;
	logic       next_cfg_reply;
	logic       next_data_xfer;
	logic       next_sync_cmd;
	logic       next_diag_reply;

	// reset released through two flops
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_s1  <= 1'b0;
			rst_n_i <= 1'b0;
		end else begin
			rst_s1  <= 1'b1;
			rst_n_i <= rst_s1;
		end
	end

	fbs_runup #(
		.CYCLES (FBS_RUNUP_W3)
	) u_runup (
		.ref_clk (ref_clk),
		.rst_n   (rst_n_i),
		.start   (addr_loaded),
		.done    (run_done)
	);

	// telegram decode and state transitions
	always_comb begin
		next_state        = state;
		next_station_addr = station_addr;
		next_addr_loaded  = addr_loaded;
		next_prm_hold     = prm_hold;
		next_active_set   = active_set;
		next_chk_cfg      = chk_cfg;
		next_chk_busy     = chk_busy;
		next_accept       = 1'b0;
		next_reject       = 1'b0;
		next_nv_write     = 1'b0;
		next_chk_req      = 1'b0;
		next_cfg_reply    = 1'b0;
		next_data_xfer    = 1'b0;
		next_sync_cmd     = 1'b0;
		next_diag_reply   = 1'b0;
		// stored address taken after reset release, not under reset
		if (!addr_loaded && nv_addr_valid) begin
			next_station_addr = nv_addr;
			next_addr_loaded  = 1'b1;
		end
		// application verdict on a pending configuration
		if (chk_busy && chk_done) begin
			next_chk_busy = 1'b0;
			if (chk_result == FBS_CHK_BAD) begin
				next_state = FBS_ST_WAIT_PRM;
			end else begin
				next_active_set = chk_cfg;
				next_state      = FBS_ST_DATA_EXCH;
			end
		end else if (tel_valid) begin
			// query answered regardless of state
			if (tel.tg == FBS_TG_GET_CFG) begin
				next_accept    = 1'b1;
				next_cfg_reply = 1'b1;
			end else begin
				case (state)
				FBS_ST_POWER_ON: begin
					if (tel.tg == FBS_TG_SET_ADDR && tel.from_class2) begin
						next_accept       = 1'b1;
						next_station_addr = tel.new_addr;
						next_nv_write     = 1'b1;
					end else if (tel.tg == FBS_TG_SET_PRM && run_done) begin
						next_accept        = 1'b1;
						next_prm_hold      = '0;
						next_prm_hold.ident     = tel.ident;
						next_prm_hold.sync_ok   = tel.sync_ok;
						next_prm_hold.freeze_ok = tel.freeze_ok;
						next_prm_hold.wd_time   = tel.wd_time;
						next_state         = FBS_ST_WAIT_CFG;
					end else begin
						next_reject = 1'b1;
					end
				end
				FBS_ST_WAIT_PRM: begin
					// data exchange and address change refused here
					if (tel.tg == FBS_TG_SET_PRM) begin
						next_accept        = 1'b1;
						next_prm_hold.ident     = tel.ident;
						next_prm_hold.sync_ok   = tel.sync_ok;
						next_prm_hold.freeze_ok = tel.freeze_ok;
						next_prm_hold.wd_time   = tel.wd_time;
						next_state         = FBS_ST_WAIT_CFG;
					end else begin
						next_reject = 1'b1;
					end
				end
				FBS_ST_WAIT_CFG: begin
					if (tel.tg == FBS_TG_CHK_CFG && !chk_busy) begin
						next_accept            = 1'b1;
						next_chk_cfg           = prm_hold;
						next_chk_cfg.in_bytes  = tel.in_bytes;
						next_chk_cfg.out_bytes = tel.out_bytes;
						next_chk_req           = 1'b1;
						next_chk_busy          = 1'b1;
					end else if (tel.tg == FBS_TG_SET_PRM && !chk_busy) begin
						next_accept        = 1'b1;
						next_prm_hold.ident     = tel.ident;
						next_prm_hold.sync_ok   = tel.sync_ok;
						next_prm_hold.freeze_ok = tel.freeze_ok;
						next_prm_hold.wd_time   = tel.wd_time;
					end else begin
						next_reject = 1'b1;
					end
				end
				FBS_ST_DATA_EXCH: begin
					// accepted set while exchanging
					case (tel.tg)
					FBS_TG_DATA_EXCH, FBS_TG_RD_INP, FBS_TG_RD_OUTP: begin
						next_accept    = 1'b1;
						next_data_xfer = 1'b1;
					end
					FBS_TG_GLOBAL_CTRL: begin
						next_accept   = 1'b1;
						next_sync_cmd = 1'b1;
					end
					FBS_TG_SLAVE_DIAG: begin
						next_accept     = 1'b1;
						next_diag_reply = 1'b1;
					end
					FBS_TG_CHK_CFG: begin
						// accepted only when it matches the running set
						if (tel.in_bytes == active_set.in_bytes &&
							tel.out_bytes == active_set.out_bytes) begin
							next_accept = 1'b1;
						end else begin
							next_reject = 1'b1;
							next_state  = FBS_ST_WAIT_PRM;
						end
					end
					FBS_TG_SET_PRM: begin
						next_accept = 1'b1;
					end
					default: begin
						next_reject = 1'b1;
					end
					endcase
				end
				default: begin
					next_reject = 1'b1;
				end
				endcase
			end
		end
	end

	// registered state and pulses
	always_ff @(posedge ref_clk or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state        <= FBS_ST_POWER_ON;
			station_addr <= FBS_ADDR_RST;
			addr_loaded  <= 1'b0;
			prm_hold     <= '0;
			active_set   <= '0;
			chk_cfg      <= '0;
			chk_busy     <= 1'b0;
			tel_accept   <= 1'b0;
			tel_reject   <= 1'b0;
			nv_write     <= 1'b0;
			chk_req      <= 1'b0;
			cfg_reply    <= 1'b0;
			data_xfer    <= 1'b0;
			sync_cmd     <= 1'b0;
			diag_reply   <= 1'b0;
		end else begin
			state        <= next_state;
			station_addr <= next_station_addr;
			addr_loaded  <= next_addr_loaded;
			prm_hold     <= next_prm_hold;
			active_set   <= next_active_set;
			chk_cfg      <= next_chk_cfg;
			chk_busy     <= next_chk_busy;
			tel_accept   <= next_accept;
			tel_reject   <= next_reject;
			nv_write     <= next_nv_write;
			chk_req      <= next_chk_req;
			cfg_reply    <= next_cfg_reply;
			data_xfer    <= next_data_xfer;
			sync_cmd     <= next_sync_cmd;
			diag_reply   <= next_diag_reply;
		end
	end
endmodule

// ### verif/fbs_master_model.sv
// bus master and application stand-in
`timescale 1ns/1ns
module fbs_master_model (
	input  wire logic              ref_clk,
	input  wire logic              chk_req,
	input  wire fbs_pkg::fbs_chk_t verdict,
	input  wire logic [3:0]        lag,
	output logic                   tel_valid,
	output fbs_pkg::fbs_tel_t      tel,
	output logic                   chk_done,
	output fbs_pkg::fbs_chk_t      chk_result
);
	import fbs_pkg::*;
	initial begin
		tel_valid = 1'b0;
		tel = '0;
		chk_done = 1'b0;
		chk_result = FBS_CHK_OK;
	end
	// one telegram per high cycle; released lines show the inverse, not stale data
	task automatic send(input fbs_tel_t t);
		@(posedge ref_clk);
		#1 tel_valid = 1'b1;
		tel = t;
		@(posedge ref_clk);
		#1 tel_valid = 1'b0;
		tel = ~t;
	endtask
	// verdict after a prompt or slow lag
	always @(posedge ref_clk) if (chk_req) begin
		repeat (lag) @(posedge ref_clk);
		#1 chk_done = 1'b1;
		chk_result = verdict;
		@(posedge ref_clk);
		#1 chk_done = 1'b0;
		chk_result = fbs_chk_t'(~verdict);
	end
endmodule

// ### verif/fbs_slave_fsm_asserts.sv
// concurrent checks on the slave state machine ports
`timescale 1ns/1ns
module fbs_slave_fsm_asserts (
	input wire logic                ref_clk,
	input wire logic                reset_n,
	input wire logic                tel_valid,
	input wire fbs_pkg::fbs_tel_t   tel,
	input wire logic                chk_done,
	input wire fbs_pkg::fbs_chk_t   chk_result,
	input wire logic                tel_accept,
	input wire logic                tel_reject,
	input wire logic                nv_write,
	input wire logic                chk_req,
	input wire fbs_pkg::fbs_set_t   chk_cfg,
	input wire fbs_pkg::fbs_set_t   active_set,
	input wire logic                cfg_reply,
	input wire logic                data_xfer,
	input wire fbs_pkg::fbs_state_t state
);
	import fbs_pkg::*;
	logic pend;
	logic busy;
	logic tv;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	// check pending from request to verdict; a telegram in the verdict cycle is dropped
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) pend <= 1'b0;
		else pend <= (pend | chk_req) & ~chk_done;
	end
	// the request cycle already counts as busy, as the design's own flag does
	assign busy = pend | chk_req;
	assign tv = tel_valid & ~(busy & chk_done);
	a_one_answer: assert property (!(tel_accept && tel_reject)) else $error("both answers");
	a_addr_gate: assert property (tv && tel.tg == FBS_TG_SET_ADDR &&
		(state != FBS_ST_POWER_ON || !tel.from_class2) |=> tel_reject && !nv_write)
		else $error("address change taken");
	a_wait_refuse: assert property (tv && state == FBS_ST_WAIT_PRM &&
		!(tel.tg inside {FBS_TG_SET_PRM, FBS_TG_GET_CFG}) |=> tel_reject) else $error("not refused");
	a_no_early_data: assert property (data_xfer |-> state == FBS_ST_DATA_EXCH)
		else $error("early data");
	a_query_any: assert property (tv && tel.tg == FBS_TG_GET_CFG |=> tel_accept && cfg_reply)
		else $error("query lost");
	a_cfg_handoff: assert property (tv && !busy && state == FBS_ST_WAIT_CFG &&
		tel.tg == FBS_TG_CHK_CFG |=> chk_req && chk_cfg.in_bytes == $past(tel.in_bytes)
		&& chk_cfg.out_bytes == $past(tel.out_bytes)) else $error("config not passed");
	a_good_enter: assert property (busy && chk_done && chk_result != FBS_CHK_BAD |=>
		state == FBS_ST_DATA_EXCH && active_set == $past(chk_cfg)) else $error("no entry");
	a_bad_drop: assert property (busy && chk_done && chk_result == FBS_CHK_BAD |=>
		(state == FBS_ST_WAIT_PRM && !data_xfer)[*2]) else $error("no fallback");
	a_exch_take: assert property (tv && state == FBS_ST_DATA_EXCH && tel.tg inside
		{FBS_TG_RD_INP, FBS_TG_RD_OUTP, FBS_TG_GLOBAL_CTRL, FBS_TG_SLAVE_DIAG}
		|=> tel_accept && !tel_reject) else $error("exchange refused");
	a_exch_data: assert property (tv && state == FBS_ST_DATA_EXCH &&
		tel.tg == FBS_TG_DATA_EXCH |=> data_xfer) else $error("no data");
	c_addr: cover property (nv_write);
	c_enter: cover property (busy && chk_done && chk_result == FBS_CHK_ADAPT);
	c_drop: cover property (busy && chk_done && chk_result == FBS_CHK_BAD);
endmodule
bind fbs_slave_fsm fbs_slave_fsm_asserts fbs_slave_fsm_asserts_i (.ref_clk, .reset_n,
	.tel_valid, .tel, .chk_done, .chk_result, .tel_accept, .tel_reject, .nv_write,
	.chk_req, .chk_cfg, .active_set, .cfg_reply, .data_xfer, .state);

// ### verif/fieldbus_slave_state_machine_tb_top.sv
// scoreboard testbench for the slave state machine
`timescale 1ns/1ns
module fieldbus_slave_state_machine_tb_top;
	import fbs_pkg::*;
	logic ref_clk, reset_n, tel_valid, nv_addr_valid, chk_done, tel_accept, tel_reject;
	logic nv_write, chk_req, cfg_reply, data_xfer, sync_cmd, diag_reply;
	logic [FBS_ADDR_W-1:0] nv_addr, station_addr;
	logic [3:0] lag;
	logic [31:0] lfsr = 32'h8D86042D;
	logic [5:0] expq[$];
	logic [5:0] note;
	logic [4:0] pul;
	fbs_tel_t tel, last, cfg, odd;
	fbs_chk_t chk_result, verdict;
	fbs_set_t chk_cfg, active_set;
	fbs_state_t state;
	fbs_chk_t vs[3] = '{FBS_CHK_BAD, FBS_CHK_ADAPT, FBS_CHK_OK};
	int fails = 0;
	int compares = 0;
	fbs_slave_fsm fbs_slave_fsm_i (.ref_clk, .reset_n, .tel_valid, .tel, .nv_addr,
		.nv_addr_valid, .chk_done, .chk_result, .tel_accept, .tel_reject, .nv_write,
		.station_addr, .chk_req, .chk_cfg, .active_set, .cfg_reply, .data_xfer,
		.sync_cmd, .diag_reply, .state);
	fbs_master_model fbs_master_model_i (.ref_clk, .chk_req, .verdict, .lag, .tel_valid,
		.tel, .chk_done, .chk_result);
	function automatic logic [31:0] rnd(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	// kind and expected {accept, reject} noted before sending
	task automatic put(input fbs_tel_t t, input logic [1:0] e);
		expq.push_back({t.tg, e});
		fbs_master_model_i.send(t);
		last = t;
	endtask
	// random fields around a chosen kind
	task automatic tx(input fbs_tg_t g, input logic c2, input logic [1:0] e);
		fbs_tel_t t;
		lfsr = rnd(lfsr);
		t = {g, c2, lfsr[6:0], lfsr[31:16], lfsr[9:8], lfsr[15:0], lfsr[23:8]};
		put(t, e);
	endtask
	task automatic stop_test();
		if (fails == 0 && compares > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// answer watcher takes the oldest note; mid-cycle, so the pulses have settled
	always @(negedge ref_clk) begin
		if (|{tel_accept, tel_reject, nv_write, cfg_reply, data_xfer, sync_cmd, diag_reply}) begin
			note = (expq.size() == 0) ? 6'h00 : expq.pop_front();
			// response pulse follows from the kind of an accepted telegram
			pul = {note[1] && note[5:2] == FBS_TG_SET_ADDR,
				note[1] && note[5:2] == FBS_TG_GET_CFG,
				note[1] && note[5:2] inside {FBS_TG_DATA_EXCH, FBS_TG_RD_INP, FBS_TG_RD_OUTP},
				note[1] && note[5:2] == FBS_TG_GLOBAL_CTRL,
				note[1] && note[5:2] == FBS_TG_SLAVE_DIAG};
			check({tel_accept, tel_reject}, note[1:0]);
			check({nv_write, cfg_reply, data_xfer, sync_cmd, diag_reply}, pul);
		end
	end
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	initial begin
		#20000 fails++;
		stop_test();
	end
	initial begin
		reset_n = 1'b0;
		nv_addr = 7'h05;
		nv_addr_valid = 1'b0;
		verdict = FBS_CHK_OK;
		lag = 4'h0;
		repeat (6) @(posedge ref_clk);
		#1 reset_n = 1'b1;
		repeat (3) @(posedge ref_clk);
		#1 nv_addr_valid = 1'b1;
		@(posedge ref_clk);
		#1 nv_addr_valid = 1'b0;
		check(station_addr, 7'h05);
		tx(FBS_TG_SET_ADDR, 1'b0, 2'b01);
		tx(FBS_TG_SET_ADDR, 1'b1, 2'b10);
		check(station_addr, last.new_addr);
		tx(FBS_TG_DATA_EXCH, 1'b0, 2'b01);
		for (int i = 0; i < 3; i++) begin
			tx(FBS_TG_SET_PRM, 1'b0, 2'b10);
			check(state, FBS_ST_WAIT_CFG);
			verdict = vs[i];
			lag = 4'(i * 3);
			tx(FBS_TG_CHK_CFG, 1'b0, 2'b10);
			cfg = last;
			for (int k = 0; k < 20 && state == FBS_ST_WAIT_CFG; k++) begin
				@(posedge ref_clk);
				#1;
			end
			if (i == 0) begin
				check(state, FBS_ST_WAIT_PRM);
				for (int g = 0; g < 10; g++)
					if (g != 1) tx(fbs_tg_t'(g), 1'b1, g == 3 ? 2'b10 : 2'b01);
			end else begin
				check(state, FBS_ST_DATA_EXCH);
				check({active_set.in_bytes, active_set.out_bytes}, {cfg.in_bytes, cfg.out_bytes});
				for (int g = 0; g < 9; g++)
					if (g != 2) tx(fbs_tg_t'(g), 1'b1, g == 0 ? 2'b01 : 2'b10);
				put(cfg, 2'b10);
				check(state, FBS_ST_DATA_EXCH);
				// byte count forced off the running set so the refusal is certain
				odd = cfg;
				odd.in_bytes = ~cfg.in_bytes;
				put(odd, 2'b01);
				check(state, FBS_ST_WAIT_PRM);
			end
		end
		repeat (3) @(posedge ref_clk);
		check(expq.size(), 0);
		stop_test();
	end
endmodule
